// ===== design/ocl_map.svh
// Constants for the oscillator clock-loss monitor: counts, ratios and idle levels
`ifndef OCL_MAP_SVH
`define OCL_MAP_SVH

// =====================================================================
// Detection timing
// Backup clock periods without an oscillator toggle before loss is declared
`define OCL_LOSS_PERIODS 9
// Width of the idle-period counter
`define OCL_LOSS_CNT_W 4

// =====================================================================
// Clock output ratios
// Fixed ratio of each system clock output to its source
`define OCL_SYS_DIV 4

// =====================================================================
// Reset and idle levels
// Error pin level when no fault has been seen
`define OCL_ERR_IDLE 1'b1
// Level of a gated clock output whose pad receiver is off
`define OCL_CLK_IDLE 1'b0

`endif

// ===== design/ocl_pkg.sv
// Types shared by the oscillator clock-loss monitor files
package ocl_pkg;

  // =====================================================================
  // Monitor states
  typedef enum logic {
    OCL_MON_WATCH,
    OCL_MON_LOST
  } ocl_mon_state_t;

endpackage : ocl_pkg

// ===== design/ocl_clk_div.sv
// Edge-counting clock divider with a pad-receiver gate on its output
`timescale 1ns/1ps
`default_nettype none
`include "ocl_map.svh"

module ocl_clk_div #(
  parameter int DIV = `OCL_SYS_DIV
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic src_i,
  input wire logic pad_on_i,
  output logic clk_div_o
);

  // Rising edges of the source between two toggles of the output
  localparam int HALF = DIV / 2;
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic src_prev_q;
  logic src_prev_d;
  logic [CW-1:0] edge_cnt_q;
  logic [CW-1:0] edge_cnt_d;
  logic div_q;
  logic div_d;
  logic out_q;
  logic out_d;
  logic rise;

  // =====================================================================
  // Divider next state
  // Counting source edges keeps one clock domain; the source must be
  // slower than half the sampling clock to be followed exactly.
  always_comb begin
    src_prev_d = src_i;
    edge_cnt_d = edge_cnt_q;
    div_d = div_q;
    rise = src_i && !src_prev_q;
    if (rise) begin
      if (edge_cnt_q == LAST) begin
        edge_cnt_d = '0;
        div_d = !div_q;
      end else begin
        edge_cnt_d = edge_cnt_q + CW'(1);
      end
    end
    // Without the receiver on, the pad is held quiet
    out_d = pad_on_i ? div_d : `OCL_CLK_IDLE;
  end

  // Divider registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      src_prev_q <= 1'b0;
      edge_cnt_q <= '0;
      div_q <= 1'b0;
      out_q <= `OCL_CLK_IDLE;
    end else begin
      src_prev_q <= src_prev_d;
      edge_cnt_q <= edge_cnt_d;
      div_q <= div_d;
      out_q <= out_d;
    end
  end

  assign clk_div_o = out_q;

endmodule : ocl_clk_div
`default_nettype wire

// ===== design/ocl_monitor.sv
// Oscillator clock-loss monitor with fail-over, error pin and debug clock outputs
// Clocking
// clk_i is the free-running backup clock itself; every register runs on it.
// The oscillator and the clock sources are sampled as levels on clk_i, so a
// source must toggle slower than half of clk_i to be followed edge for edge.
// A faster oscillator still reads as alive: any change between two samples
// restarts the idle window, and only a stopped clock is reported.
//
// Fail-over
// The switch enable is sampled once, in the cycle that declares the loss;
// changing it afterwards has no effect until the next reset.
// The reference mux is a plain select, not a glitch-free switch: it relies
// on the oscillator having stopped by the time the select moves.
//
// Fault reporting
// There is no clear for a latched loss. The error pin stays low until the
// outside supervisor resets or power-cycles the device, which is the only
// way back to watching the oscillator.
//
// Debug clocks
// The divided system clocks and the observation clocks are registered, so
// each lags its source by a cycle and shows fast sources aliased.
// Without the pad receiver on, every clock output rests at its idle level.
`timescale 1ns/1ps
`default_nettype none
`include "ocl_map.svh"

module ocl_monitor #(
  parameter int OBS_NUM = 4,
  parameter int OBS_SEL_W = 2
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic main_osc_clk_i,
  input wire logic loss_switch_enable_i,
  input wire logic main_sys_clock_i,
  input wire logic safety_sys_clock_src_i,
  input wire logic [OBS_NUM-1:0] observe_srcs_i,
  input wire logic [OBS_SEL_W-1:0] observe_sel_i,
  input wire logic [OBS_NUM-1:0] safety_observe_srcs_i,
  input wire logic [OBS_SEL_W-1:0] safety_observe_sel_i,
  input wire logic sys_pad_receiver_on_i,
  input wire logic safety_sys_pad_receiver_on_i,
  input wire logic observe_pad_receiver_on_i,
  input wire logic safety_observe_pad_receiver_on_i,
  output logic main_osc_ref_out_o,
  output logic ref_on_backup_o,
  output logic clock_loss_o,
  output logic error_out_n_o,
  output logic sys_clock_out_o,
  output logic safety_sys_clock_out_o,
  output logic observe_clock_out_o,
  output logic safety_observe_clock_out_o
);

  // =====================================================================
  // Local constants
  // Counter width and loss limit, taken from the shared map
  localparam int CNT_W = `OCL_LOSS_CNT_W;
  localparam int LOSS_N = `OCL_LOSS_PERIODS;
  localparam logic [CNT_W-1:0] LOSS_LAST = CNT_W'(LOSS_N);

  // =====================================================================
  // Clock-loss detection
  // clk_i is the free-running backup clock; the oscillator is sampled on it.
  ocl_pkg::ocl_mon_state_t state_q;
  ocl_pkg::ocl_mon_state_t state_d;
  logic osc_prev_q;
  logic osc_prev_d;
  logic [`OCL_LOSS_CNT_W-1:0] idle_cnt_q;
  logic [`OCL_LOSS_CNT_W-1:0] idle_cnt_d;
  // Latched outcome of a loss: fail-over choice and error pin level
  logic use_backup_q;
  logic use_backup_d;
  logic err_n_q;
  logic err_n_d;

  // Monitor next state
  always_comb begin
    state_d = state_q;
    osc_prev_d = main_osc_clk_i;
    idle_cnt_d = idle_cnt_q;
    use_backup_d = use_backup_q;
    err_n_d = err_n_q;
    case (state_q)
      ocl_pkg::OCL_MON_WATCH: begin
        if (main_osc_clk_i != osc_prev_q) begin
          idle_cnt_d = '0; // Any edge restarts the idle window
        end else begin
          idle_cnt_d = idle_cnt_q + `OCL_LOSS_CNT_W'(1);
          if (idle_cnt_d == LOSS_LAST) begin
            state_d = ocl_pkg::OCL_MON_LOST;
            err_n_d = 1'b0;
            // Switch enable is sampled only at the moment of loss
            use_backup_d = loss_switch_enable_i;
          end
        end
      end
      ocl_pkg::OCL_MON_LOST: begin
        // Only reset leaves this state; a restarted oscillator is ignored
        idle_cnt_d = idle_cnt_q;
        err_n_d = 1'b0;
      end
      default: begin
        state_d = ocl_pkg::OCL_MON_WATCH;
        idle_cnt_d = '0;
      end
    endcase
  end

  // Monitor registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= ocl_pkg::OCL_MON_WATCH;
      osc_prev_q <= 1'b0;
      idle_cnt_q <= '0;
      use_backup_q <= 1'b0;
      err_n_q <= `OCL_ERR_IDLE;
    end else begin
      state_q <= state_d;
      osc_prev_q <= osc_prev_d;
      idle_cnt_q <= idle_cnt_d;
      use_backup_q <= use_backup_d;
      err_n_q <= err_n_d;
    end
  end

  // Pins come straight from registers, so they never glitch
  assign clock_loss_o = (state_q == ocl_pkg::OCL_MON_LOST);
  assign error_out_n_o = err_n_q;
  assign ref_on_backup_o = use_backup_q;

  // =====================================================================
  // Reference clock selection
  // A plain mux: the switch happens after the oscillator is already dead,
  // so no live edge of it can glitch against the backup clock.
  always_comb begin
    main_osc_ref_out_o = use_backup_q ? clk_i : main_osc_clk_i;
  end

  // =====================================================================
  // Fixed system clock outputs
  logic [1:0] sys_src;
  logic [1:0] sys_pad_on;
  logic [1:0] sys_out;

  // Sources are hardwired; no select input exists for these pins
  assign sys_src = {safety_sys_clock_src_i, main_sys_clock_i};
  assign sys_pad_on = {safety_sys_pad_receiver_on_i, sys_pad_receiver_on_i};

  // One divider per domain, each counting edges of its own source
  generate
    for (genvar g = 0; g < 2; g++) begin : g_sys
      ocl_clk_div #(
        .DIV(`OCL_SYS_DIV)
      ) u_div (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .src_i(sys_src[g]),
        .pad_on_i(sys_pad_on[g]),
        .clk_div_o(sys_out[g])
      );
    end
  endgenerate

  assign sys_clock_out_o = sys_out[0];
  assign safety_sys_clock_out_o = sys_out[1];

  // =====================================================================
  // Observation clock outputs
  // Debug only: sampled on clk_i, so a fast source shows aliased.
  logic [OBS_NUM-1:0] obs_srcs [2];
  logic [OBS_SEL_W-1:0] obs_sel [2];
  logic [1:0] obs_pad_on;
  logic [1:0] obs_q;
  logic [1:0] obs_d;

  // Gather both domains so that one loop serves them
  assign obs_srcs[0] = observe_srcs_i;
  assign obs_srcs[1] = safety_observe_srcs_i;
  assign obs_sel[0] = observe_sel_i;
  assign obs_sel[1] = safety_observe_sel_i;
  assign obs_pad_on = {safety_observe_pad_receiver_on_i, observe_pad_receiver_on_i};

  // One selector and one output register per domain
  generate
    for (genvar h = 0; h < 2; h++) begin : g_obs
      // Select one clock; out-of-range selects show the idle level
      always_comb begin
        obs_d[h] = `OCL_CLK_IDLE;
        if (obs_pad_on[h] && (int'(obs_sel[h]) < OBS_NUM)) begin
          obs_d[h] = obs_srcs[h][obs_sel[h]];
        end
      end

      // Observation output register
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          obs_q[h] <= `OCL_CLK_IDLE;
        end else begin
          obs_q[h] <= obs_d[h];
        end
      end
    end
  endgenerate

  assign observe_clock_out_o = obs_q[0];
  assign safety_observe_clock_out_o = obs_q[1];

endmodule : ocl_monitor
`default_nettype wire

// ===== dv/ocl_monitor_checker.sv
// Port-level assertions for the oscillator clock-loss monitor
`timescale 1ns/1ps
`default_nettype none
`include "ocl_map.svh"
module ocl_monitor_checker #(
  parameter int OBS_NUM = 4,
  parameter int OBS_SEL_W = 2
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic main_osc_clk_i,
  input wire logic loss_switch_enable_i,
  input wire logic main_sys_clock_i,
  input wire logic [OBS_NUM-1:0] observe_srcs_i,
  input wire logic [OBS_SEL_W-1:0] observe_sel_i,
  input wire logic sys_pad_receiver_on_i,
  input wire logic observe_pad_receiver_on_i,
  input wire logic ref_on_backup_o,
  input wire logic clock_loss_o,
  input wire logic error_out_n_o,
  input wire logic sys_clock_out_o,
  input wire logic observe_clock_out_o
);
  logic obs_q;
  // Expected debug level, one cycle behind its chosen source
  always_ff @(posedge clk_i) begin
    obs_q <= !reset_i && observe_pad_receiver_on_i && observe_srcs_i[observe_sel_i];
  end
  localparam int LOSS_N = `OCL_LOSS_PERIODS;
  logic osc_seen_q;
  logic [3:0] idle_run_q;
  // Own count of equal oscillator samples; saturates so it never wraps
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      osc_seen_q <= 1'b0;
      idle_run_q <= 4'H0;
    end else begin
      osc_seen_q <= main_osc_clk_i;
      if (main_osc_clk_i != osc_seen_q) idle_run_q <= 4'H0;
      else if (idle_run_q != 4'HF) idle_run_q <= idle_run_q + 4'H1;
    end
  end
  // ======
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Idle window full: the limit of equal samples has been reached
  sequence idle_full;
    idle_run_q >= LOSS_N;
  endsequence
  chk_loss_after_idle: assert property (idle_full |-> clock_loss_o)
    else $error("loss late");
  chk_loss_not_early: assert property ($rose(clock_loss_o) |-> idle_run_q == LOSS_N)
    else $error("loss early");
  chk_loss_latched: assert property (clock_loss_o |=> clock_loss_o)
    else $error("loss dropped");
  chk_err_pin_low: assert property (error_out_n_o == !clock_loss_o)
    else $error("error pin wrong");
  chk_switch_on_loss: assert property ($rose(clock_loss_o) |->
    ref_on_backup_o == $past(loss_switch_enable_i)) else $error("switch wrong");
  chk_backup_holds: assert property (ref_on_backup_o |-> clock_loss_o ##1 ref_on_backup_o)
    else $error("backup lost");
  chk_div_on_rise: assert property ($changed(sys_clock_out_o) && $past(sys_pad_receiver_on_i)
    && $past(sys_pad_receiver_on_i, 2) |-> $past(main_sys_clock_i)
    && !$past(main_sys_clock_i, 2)) else $error("divider moved off a rise");
  chk_pad_gate: assert property ((!sys_pad_receiver_on_i)[*2] |-> !sys_clock_out_o)
    else $error("gated output high");
  chk_obs_select: assert property (observe_clock_out_o == obs_q)
    else $error("observe wrong");
endmodule : ocl_monitor_checker
bind ocl_monitor ocl_monitor_checker #(.OBS_NUM(OBS_NUM), .OBS_SEL_W(OBS_SEL_W)) u_chk (.*);
`default_nettype wire

// ===== dv/ocl_supervisor_model.sv
// Board supervisor model watching the error pin
`timescale 1ns/1ps
`default_nettype none
module ocl_supervisor_model #(
  parameter int HOLD = 12
) (
  input wire logic clk_i,
  input wire logic error_out_n_i,
  output logic power_cycle_o
);
  logic [3:0] low_q;
  // Count low cycles; the monitor never recovers itself, so we power-cycle
  always_ff @(posedge clk_i) begin
    low_q <= error_out_n_i ? 4'H0 : low_q + 4'H1;
  end
  assign power_cycle_o = low_q >= 4'(HOLD);
endmodule : ocl_supervisor_model
`default_nettype wire

// ===== dv/test_ocl_monitor.sv
// Self-checking bench for the oscillator clock-loss monitor
`timescale 1ns/1ps
`default_nettype none
module test_ocl_monitor;
  logic clk_i = 1'b0, rst = 1'b1, osc = 1'b0, run = 1'b0, sw = 1'b0, pad = 1'b0;
  logic [2:0] ph = 3'H0;
  logic [3:0] srcs = 4'H0;
  logic [1:0] sel = 2'H0;
  logic ref_o, bk, loss, err_n, so, sso, oo, soo, pwr;
  int errors = 0, n_compared = 0, cyc = 0;
  // ======
  // Design and supervisor; one pad enable for all, own source and select for safety
  ocl_monitor u_dut (.clk_i(clk_i), .reset_i(rst | pwr), .main_osc_clk_i(osc),
    .loss_switch_enable_i(sw), .main_sys_clock_i(ph[2]), .safety_sys_clock_src_i(ph[1]),
    .observe_srcs_i(srcs), .observe_sel_i(sel), .safety_observe_srcs_i(srcs),
    .safety_observe_sel_i(~sel), .sys_pad_receiver_on_i(pad),
    .safety_sys_pad_receiver_on_i(pad), .observe_pad_receiver_on_i(pad),
    .safety_observe_pad_receiver_on_i(pad), .main_osc_ref_out_o(ref_o),
    .ref_on_backup_o(bk), .clock_loss_o(loss), .error_out_n_o(err_n),
    .sys_clock_out_o(so), .safety_sys_clock_out_o(sso), .observe_clock_out_o(oo),
    .safety_observe_clock_out_o(soo));
  ocl_supervisor_model u_sup (.clk_i(clk_i), .error_out_n_i(err_n), .power_cycle_o(pwr));
  always #5 clk_i = ~clk_i;
  // Stimulus clocks and hang guard
  always @(posedge clk_i) begin
    ph <= ph + 3'H1;
    if (run) osc <= ~osc;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // ======
  // Scenarios
  task automatic t_div();
    logic [7:0] n;
    logic [7:0] m;
    logic p;
    logic q;
    n = 8'H0;
    m = 8'H0;
    @(posedge clk_i) pad <= 1'b1;
    repeat (8) @(posedge clk_i);
    p = so;
    q = sso;
    // Source periods 8 and 4 give 32 and 16: four and eight toggles in 64 cycles
    repeat (64) begin
      @(posedge clk_i);
      n += {7'H0, so !== p};
      m += {7'H0, sso !== q};
      p = so;
      q = sso;
    end
    check(n, 8'H4);
    check(m, 8'H8);
    pad <= 1'b0;
    srcs <= 4'HF;
    repeat (2) @(posedge clk_i);
    n = 8'H0;
    repeat (20) @(posedge clk_i) n += {4'H0, so, sso, oo, soo};
    check(n, 8'H0);
    pad <= 1'b1;
  endtask : t_div
  task automatic t_obs();
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      sel <= k[2:1];
      srcs <= k[0] ? 4'H1 << k[2:1] : ~(4'H1 << k[2:1]);
      repeat (2) @(posedge clk_i);
      #1 check({oo, soo}, {k[0], !k[0]});
    end
  endtask : t_obs
  task automatic t_loss(input logic s);
    int w;
    @(posedge clk_i) sw <= s;
    repeat (12) @(posedge clk_i);
    check({loss, err_n}, 8'H1);
    run <= 1'b0;
    repeat (9) @(posedge clk_i);
    #1 check(loss, 8'H0);
    @(posedge clk_i);
    #1 check({loss, err_n, bk}, {2'H2, s});
    @(negedge clk_i) check(ref_o, s ? 1'b0 : osc);
    @(posedge clk_i) run <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1 check({loss, err_n, bk}, {2'H2, s});
    w = 0;
    while (err_n !== 1'b1 && w < 30) @(posedge clk_i) w++;
    @(posedge clk_i);
    #1 check({loss, bk}, 8'H0);
  endtask : t_loss
  initial begin
    repeat (6) @(posedge clk_i);
    rst <= 1'b0;
    run <= 1'b1;
    t_div();
    t_obs();
    t_loss(1'b0);
    t_loss(1'b1);
    conclude();
  end
endmodule : test_ocl_monitor
`default_nettype wire
